// *** include/dcub_params.svh ***
`ifndef DCUB_PARAMS_SVH
`define DCUB_PARAMS_SVH

// clock and power-system timing
`define DCUB_CLK_HZ         20000000
`define DCUB_LINE_HZ        60
`define DCUB_TICKS_PER_CYC  4
`define DCUB_DIV_W          17

// delay settings, in tenths of a power-system cycle, as typically set
`define DCUB_QUAL_DLY_CYC_X10   5
`define DCUB_DIS_DLY_CYC_X10    90
`define DCUB_GUARD_DLY_CYC_X10  100
`define DCUB_DLY_W              8

// apb register map, byte addresses
`define DCUB_ADDR_W         8
`define DCUB_ADDR_CTRL      8'h00
`define DCUB_ADDR_QUAL_DLY  8'h04
`define DCUB_ADDR_DIS_DLY   8'h08
`define DCUB_ADDR_GUARD_DLY 8'h0C
`define DCUB_ADDR_STATE     8'h10
`define DCUB_ADDR_INT_STAT  8'h14
`define DCUB_ADDR_INT_MASK  8'h18

// interrupt event bits: loss1, loss2, block1, block2
`define DCUB_EV_W           4
`define DCUB_STATE_W        9
`define DCUB_SCHEME_W       2

`endif

// *** include/dcub_pkg.sv ***
`include "dcub_params.svh"

package dcub_pkg;

   typedef enum logic [`DCUB_SCHEME_W-1:0]
   {
      DCUB_SCH_OFF  = 2'b00,
      DCUB_SCH_POTT = 2'b01,
      DCUB_SCH_UB2T = 2'b10,
      DCUB_SCH_UB3T = 2'b11
   } dcub_scheme_type;

   typedef enum logic [1:0]
   {
      DCUB_CH_NORMAL = 2'b00,
      DCUB_CH_LOSS   = 2'b01,
      DCUB_CH_BLOCK  = 2'b10
   } dcub_chan_mode_type;

   typedef struct packed
   {
      logic loss;
      logic combined_unblock_block;
      logic combined_permissive_receive;
   } dcub_chan_out_type;

   typedef struct packed
   {
      logic [`DCUB_DLY_W-1:0] qual_dly;
      logic [`DCUB_DLY_W-1:0] dis_dly;
      logic [`DCUB_DLY_W-1:0] guard_dly;
   } dcub_delays_type;

   typedef struct packed
   {
      dcub_chan_mode_type     mode;
      logic [`DCUB_DLY_W-1:0] qual_cnt;
      logic [`DCUB_DLY_W-1:0] dis_cnt;
      logic [`DCUB_DLY_W-1:0] guard_cnt;
      dcub_chan_out_type      out;
   } dcub_chan_state_type;

   typedef struct packed
   {
      logic [3:0]              sync1;
      logic [3:0]              sync2;
      logic [`DCUB_DIV_W-1:0]  div_cnt;
      logic                    tick;
      dcub_scheme_type         scheme;
      dcub_delays_type         dly;
      logic [`DCUB_EV_W-1:0]   prev_ev;
      logic [`DCUB_EV_W-1:0]   int_stat;
      logic [`DCUB_EV_W-1:0]   int_mask;
      logic [1:0]              combined_permissive_receive;
      logic [1:0]              combined_unblock_block;
      logic                    comb_ubb;
      logic                    comb_combined_permissive_receive;
      logic                    echo_pt;
      logic                    pott_en;
      logic                    irq;
      logic [31:0]             prdata;
      logic                    pready;
      logic                    pslverr;
   } dcub_top_state_type;

endpackage

// *** logic/dcub_channel.sv ***
`timescale 1ns/100ps
`default_nettype none

module dcub_channel
   import dcub_pkg::*;
(
   // clock and reset
   input  wire logic              clk,
   input  wire logic              rst_n,
   // control
   input  wire logic              enable,
   input  wire logic              tick,
   input  wire dcub_delays_type   dly,
   // synchronised receiver levels
   input  wire logic              permissive,
   input  wire logic              guard_lost,
   // decisions
   output dcub_chan_out_type      chan_out
);

   dcub_chan_state_type st;
   dcub_chan_state_type next_st;
   logic                qual;
   logic                guard_done;

   assign chan_out   = st.out;
   assign guard_done = (st.guard_cnt >= dly.guard_dly);

   always_comb
   begin
      next_st = st;
      qual    = guard_lost & ~permissive;
      if (!enable)
      begin
         next_st = '0;
      end
      else
      begin
         unique case (st.mode)
            DCUB_CH_NORMAL:
            begin
               if (!qual)
               begin
                  next_st.qual_cnt = '0;
               end
               else if (tick)
               begin
                  if (st.qual_cnt >= dly.qual_dly)
                  begin
                     next_st.mode      = DCUB_CH_LOSS;
                     next_st.dis_cnt   = '0;
                     next_st.guard_cnt = '0;
                  end
                  else
                  begin
                     next_st.qual_cnt = `DCUB_DLY_W'(st.qual_cnt + 1'b1);
                  end
               end
            end
            DCUB_CH_LOSS, DCUB_CH_BLOCK:
            begin
               if (st.mode == DCUB_CH_LOSS && tick)
               begin
                  if (st.dis_cnt >= dly.dis_dly)
                  begin
                     next_st.mode = DCUB_CH_BLOCK;
                  end
                  else
                  begin
                     next_st.dis_cnt = `DCUB_DLY_W'(st.dis_cnt + 1'b1);
                  end
               end
               // guard must stay present without a break
               if (guard_lost)
               begin
                  next_st.guard_cnt = '0;
               end
               else if (tick)
               begin
                  if (st.guard_cnt >= dly.guard_dly)
                  begin
                     next_st.mode      = DCUB_CH_NORMAL;
                     next_st.qual_cnt  = '0;
                     next_st.dis_cnt   = '0;
                     next_st.guard_cnt = '0;
                  end
                  else
                  begin
                     next_st.guard_cnt = `DCUB_DLY_W'(st.guard_cnt + 1'b1);
                  end
               end
            end
            default:
            begin
               next_st.mode = DCUB_CH_NORMAL;
            end
         endcase
         next_st.out.loss = (next_st.mode != DCUB_CH_NORMAL);
         next_st.out.combined_unblock_block  = (next_st.mode == DCUB_CH_BLOCK);
         next_st.out.combined_permissive_receive = permissive | next_st.out.loss;
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st <= '0;
      end
      else
      begin
         st <= next_st;
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   sequence s_qualifying;
      guard_lost && !permissive && enable;
   endsequence

   a_loss_needs_qual: assert property ($rose(st.out.loss) |-> $past(qual))
      else $error("loss declared without qualifying condition");
   a_block_after_loss: assert property ($rose(st.out.combined_unblock_block) |-> $past(st.out.loss))
      else $error("block asserted without prior loss");
   a_off_quiet: assert property (!enable |=> st.out == '0)
      else $error("disabled channel drives an output");
   a_combined_permissive_receive_on_pt: assert property (enable && permissive |=> st.out.combined_permissive_receive)
      else $error("received permissive did not give permissive receive");
   a_guard_reset: assert property ($fell(st.out.loss) && $past(enable) |->
      $past(guard_done) && !$past(guard_lost))
      else $error("loss cleared without guard present for the guard delay");

endmodule

`default_nettype wire

// *** logic/dcub_unblock.sv ***
// The placing of the registers and the APB interface to the registers are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none

module dcub_unblock
   import dcub_pkg::*;
#(
   parameter int QCYC_CLKS = `DCUB_CLK_HZ / (`DCUB_LINE_HZ * `DCUB_TICKS_PER_CYC)
)
(
   // clock and reset
   input  wire logic                    REF_CLK,
   input  wire logic                    RST_N,
   // apb slave
   input  wire logic                    PSEL,
   input  wire logic                    PENABLE,
   input  wire logic                    PWRITE,
   input  wire logic [`DCUB_ADDR_W-1:0] PADDR,
   input  wire logic [31:0]             PWDATA,
   output logic [31:0]                  PRDATA,
   output logic                         PREADY,
   output logic                         PSLVERR,
   // receiver contacts
   input  wire logic                    CH1_PERMISSIVE_IN,
   input  wire logic                    CH2_PERMISSIVE_IN,
   input  wire logic                    CH1_GUARD_LOST_IN,
   input  wire logic                    CH2_GUARD_LOST_IN,
   // per-channel decisions
   output logic                         CH1_PERMISSIVE_RECEIVE,
   output logic                         CH2_PERMISSIVE_RECEIVE,
   output logic                         CH1_UNBLOCK_BLOCK,
   output logic                         CH2_UNBLOCK_BLOCK,
   // to trip and echo logic
   output logic                         COMBINED_UNBLOCK_BLOCK,
   output logic                         COMBINED_PERMISSIVE_RECEIVE,
   output logic                         ECHO_PERMISSIVE_IN,
   output logic                         POTT_ENABLE,
   // interrupt
   output logic                         IRQ
);

   localparam logic [`DCUB_DIV_W-1:0] DIV_LAST = `DCUB_DIV_W'(QCYC_CLKS - 1);

   localparam logic [`DCUB_DLY_W-1:0] QUAL_DLY_RST =
      `DCUB_DLY_W'((`DCUB_QUAL_DLY_CYC_X10 * `DCUB_TICKS_PER_CYC) / 10);
   localparam logic [`DCUB_DLY_W-1:0] DIS_DLY_RST =
      `DCUB_DLY_W'((`DCUB_DIS_DLY_CYC_X10 * `DCUB_TICKS_PER_CYC) / 10);
   localparam logic [`DCUB_DLY_W-1:0] GUARD_DLY_RST =
      `DCUB_DLY_W'((`DCUB_GUARD_DLY_CYC_X10 * `DCUB_TICKS_PER_CYC) / 10);

   dcub_top_state_type st;
   dcub_top_state_type next_st;
   dcub_chan_out_type  chan_out [2];
   logic [1:0]         chan_en;
   logic [1:0]         pt_sync;
   logic [1:0]         log_sync;
   logic [`DCUB_EV_W-1:0] ev_now;
   logic [`DCUB_EV_W-1:0] ev_rise;
   logic [`DCUB_EV_W-1:0] w1c;
   logic               setup;
   logic               wr_take;

   function automatic logic addr_known(input logic [`DCUB_ADDR_W-1:0] a);
      return a == `DCUB_ADDR_CTRL      || a == `DCUB_ADDR_QUAL_DLY ||
             a == `DCUB_ADDR_DIS_DLY   || a == `DCUB_ADDR_GUARD_DLY ||
             a == `DCUB_ADDR_STATE     || a == `DCUB_ADDR_INT_STAT ||
             a == `DCUB_ADDR_INT_MASK;
   endfunction

   function automatic logic is_unblock(input dcub_scheme_type s);
      return s == DCUB_SCH_UB2T || s == DCUB_SCH_UB3T;
   endfunction

   // sync2 order: {ch2 guard lost, ch1 guard lost, ch2 permissive, ch1 permissive}
   assign pt_sync  = st.sync2[1:0];
   assign log_sync = st.sync2[3:2];

   assign chan_en[0] = is_unblock(st.scheme);
   assign chan_en[1] = (st.scheme == DCUB_SCH_UB3T);

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++)
      begin : g_chan
         dcub_channel u_chan
         (
            .clk        (REF_CLK),
            .rst_n      (RST_N),
            .enable     (chan_en[gi]),
            .tick       (st.tick),
            .dly        (st.dly),
            .permissive (pt_sync[gi]),
            .guard_lost (log_sync[gi]),
            .chan_out   (chan_out[gi])
         );
      end
   endgenerate

   assign ev_now  = {chan_out[1].combined_unblock_block, chan_out[0].combined_unblock_block, chan_out[1].loss, chan_out[0].loss};
   assign ev_rise = ev_now & ~st.prev_ev;
   assign setup   = PSEL & ~PENABLE;
   assign wr_take = PSEL & PENABLE & st.pready & PWRITE & addr_known(PADDR);
   assign w1c     = (wr_take && PADDR == `DCUB_ADDR_INT_STAT) ?
                    PWDATA[`DCUB_EV_W-1:0] : '0;

   always_comb
   begin
      next_st = st;

      // input synchroniser
      next_st.sync1 = {CH2_GUARD_LOST_IN, CH1_GUARD_LOST_IN,
                       CH2_PERMISSIVE_IN, CH1_PERMISSIVE_IN};
      next_st.sync2 = st.sync1;

      // quarter power-cycle tick
      if (st.div_cnt >= DIV_LAST)
      begin
         next_st.div_cnt = '0;
         next_st.tick    = 1'b1;
      end
      else
      begin
         next_st.div_cnt = `DCUB_DIV_W'(st.div_cnt + 1'b1);
         next_st.tick    = 1'b0;
      end

      // register writes land at the access edge
      if (wr_take)
      begin
         unique case (PADDR)
            `DCUB_ADDR_CTRL:
            begin
               next_st.scheme = dcub_scheme_type'(PWDATA[`DCUB_SCHEME_W-1:0]);
            end
            `DCUB_ADDR_QUAL_DLY:
            begin
               next_st.dly.qual_dly = PWDATA[`DCUB_DLY_W-1:0];
            end
            `DCUB_ADDR_DIS_DLY:
            begin
               next_st.dly.dis_dly = PWDATA[`DCUB_DLY_W-1:0];
            end
            `DCUB_ADDR_GUARD_DLY:
            begin
               next_st.dly.guard_dly = PWDATA[`DCUB_DLY_W-1:0];
            end
            `DCUB_ADDR_INT_MASK:
            begin
               next_st.int_mask = PWDATA[`DCUB_EV_W-1:0];
            end
            default:
            begin
               next_st.scheme = st.scheme;
            end
         endcase
      end

      // sticky events, a new event wins over its clear
      next_st.prev_ev  = ev_now;
      next_st.int_stat = (st.int_stat & ~w1c) | ev_rise;
      next_st.irq      = |(next_st.int_stat & next_st.int_mask);

      // per-channel and merged outputs
      next_st.combined_permissive_receive    = {chan_out[1].combined_permissive_receive, chan_out[0].combined_permissive_receive};
      next_st.combined_unblock_block     = {chan_out[1].combined_unblock_block, chan_out[0].combined_unblock_block};
      next_st.pott_en = is_unblock(st.scheme) || st.scheme == DCUB_SCH_POTT;
      unique case (st.scheme)
         DCUB_SCH_UB2T:
         begin
            next_st.comb_ubb  = chan_out[0].combined_unblock_block;
            next_st.comb_combined_permissive_receive = chan_out[0].combined_permissive_receive;
            next_st.echo_pt   = pt_sync[0];
         end
         DCUB_SCH_UB3T:
         begin
            next_st.comb_ubb  = chan_out[0].combined_unblock_block | chan_out[1].combined_unblock_block;
            next_st.comb_combined_permissive_receive = chan_out[0].combined_permissive_receive & chan_out[1].combined_permissive_receive;
            next_st.echo_pt   = pt_sync[0] & pt_sync[1];
         end
         DCUB_SCH_POTT:
         begin
            next_st.comb_ubb  = 1'b0;
            next_st.comb_combined_permissive_receive = 1'b0;
            next_st.echo_pt   = pt_sync[0];
         end
         DCUB_SCH_OFF:
         begin
            next_st.comb_ubb  = 1'b0;
            next_st.comb_combined_permissive_receive = 1'b0;
            next_st.echo_pt   = 1'b0;
         end
      endcase

      // apb: answer prepared in setup, ready in the first access cycle
      next_st.pready  = setup;
      next_st.pslverr = setup & ~addr_known(PADDR);
      next_st.prdata  = '0;
      if (setup && !PWRITE)
      begin
         unique case (PADDR)
            `DCUB_ADDR_CTRL:
            begin
               next_st.prdata = 32'(st.scheme);
            end
            `DCUB_ADDR_QUAL_DLY:
            begin
               next_st.prdata = 32'(st.dly.qual_dly);
            end
            `DCUB_ADDR_DIS_DLY:
            begin
               next_st.prdata = 32'(st.dly.dis_dly);
            end
            `DCUB_ADDR_GUARD_DLY:
            begin
               next_st.prdata = 32'(st.dly.guard_dly);
            end
            `DCUB_ADDR_STATE:
            begin
               next_st.prdata = 32'({chan_out[1].loss, chan_out[0].loss, st.echo_pt,
                                     st.comb_ubb, st.comb_combined_permissive_receive, st.combined_unblock_block, st.combined_permissive_receive});
            end
            `DCUB_ADDR_INT_STAT:
            begin
               next_st.prdata = 32'(st.int_stat);
            end
            `DCUB_ADDR_INT_MASK:
            begin
               next_st.prdata = 32'(st.int_mask);
            end
            default:
            begin
               next_st.prdata = '0;
            end
         endcase
      end
   end

   always_ff @(posedge REF_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         st               <= '0;
         st.dly.qual_dly  <= QUAL_DLY_RST;
         st.dly.dis_dly   <= DIS_DLY_RST;
         st.dly.guard_dly <= GUARD_DLY_RST;
      end
      else
      begin
         st <= next_st;
      end
   end

   assign PRDATA                      = st.prdata;
   assign PREADY                      = st.pready;
   assign PSLVERR                     = st.pslverr;
   assign CH1_PERMISSIVE_RECEIVE      = st.combined_permissive_receive[0];
   assign CH2_PERMISSIVE_RECEIVE      = st.combined_permissive_receive[1];
   assign CH1_UNBLOCK_BLOCK           = st.combined_unblock_block[0];
   assign CH2_UNBLOCK_BLOCK           = st.combined_unblock_block[1];
   assign COMBINED_UNBLOCK_BLOCK      = st.comb_ubb;
   assign COMBINED_PERMISSIVE_RECEIVE = st.comb_combined_permissive_receive;
   assign ECHO_PERMISSIVE_IN          = st.echo_pt;
   assign POTT_ENABLE                 = st.pott_en;
   assign IRQ                         = st.irq;

   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (!RST_N);

   sequence s_apb_setup;
      PSEL && !PENABLE;
   endsequence

   sequence s_apb_access;
      PSEL && PENABLE && PREADY;
   endsequence

   a_apb_ready_next: assert property (s_apb_setup |=> PREADY)
      else $error("no ready in first access cycle");
   a_apb_ready_once: assert property (s_apb_access |=> !PREADY)
      else $error("ready held beyond one cycle");
   a_unblock_off: assert property (!is_unblock(st.scheme) [*2] |-> ##1 !COMBINED_UNBLOCK_BLOCK && !CH1_UNBLOCK_BLOCK)
      else $error("block output active with unblocking off");
   a_pott_runs: assert property (is_unblock(st.scheme) |=> POTT_ENABLE)
      else $error("permissive trip logic not enabled under unblocking");
   a_two_term_ch2: assert property (st.scheme == DCUB_SCH_UB2T [*3] |-> !CH2_UNBLOCK_BLOCK && !CH2_PERMISSIVE_RECEIVE)
      else $error("channel 2 active in two-terminal option");
   a_merge_block: assert property (st.scheme == DCUB_SCH_UB3T &&
      (chan_out[0].combined_unblock_block || chan_out[1].combined_unblock_block) |=> COMBINED_UNBLOCK_BLOCK)
      else $error("channel block not merged");
   a_merge_combined_permissive_receive: assert property (st.scheme == DCUB_SCH_UB2T && chan_out[0].combined_permissive_receive |=> COMBINED_PERMISSIVE_RECEIVE == st.combined_permissive_receive[0])
      else $error("combined permissive receive does not follow channel 1");
   a_echo_merge: assert property (st.scheme == DCUB_SCH_UB3T && pt_sync == 2'b01 |=> !ECHO_PERMISSIVE_IN)
      else $error("echo permissive without both channels");
   a_irq_event: assert property (ev_rise[0] && st.int_mask[0] |=> IRQ && st.int_stat[0])
      else $error("unmasked event did not raise interrupt");

endmodule

`default_nettype wire

// *** test/dcub_rx_model.sv ***
`timescale 1ns/100ps
`default_nettype none

// receiver contacts of both channels; slow adds one cycle of relay lag
module dcub_rx_model
(
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // bench commands
   input  wire logic       slow,
   input  wire logic [1:0] cmd_pt,
   input  wire logic [1:0] cmd_lg,
   // contacts
   output logic [1:0]      pt,
   output logic [1:0]      lg
);
   logic [3:0] lag;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         lag <= 4'h0;
         pt  <= 2'h0;
         lg  <= 2'h0;
      end
      else
      begin
         lag <= {cmd_pt, cmd_lg};
         pt  <= slow ? lag[3:2] : cmd_pt;
         lg  <= slow ? lag[1:0] : cmd_lg;
      end
   end
endmodule

`default_nettype wire

// *** test/dcub_unblock_tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "dcub_params.svh"

module dcub_unblock_tb_top
   import dcub_pkg::*;
;
   localparam int PR1 = 0, PR2 = 1, UB1 = 2, UB2 = 3, CUB = 4, CPR = 5, ECH = 6, IRQ_B = 8;
   logic                    REF_CLK, RST_N, PSEL, PENABLE, PWRITE, err, slow;
   logic [`DCUB_ADDR_W-1:0] PADDR;
   logic [31:0]             PWDATA, rd;
   logic [1:0]              cmd_pt, cmd_lg;
   wire  [1:0]              rx_pt, rx_lg;
   wire  [31:0]             PRDATA;
   wire                     PREADY, PSLVERR;
   wire  [8:0]              obs;
   int                      n_fail, n_tests, cyc;

   dcub_unblock #(.QCYC_CLKS(4)) dut
   (
      .REF_CLK(REF_CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
      .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
      .CH1_PERMISSIVE_IN(rx_pt[0]), .CH2_PERMISSIVE_IN(rx_pt[1]),
      .CH1_GUARD_LOST_IN(rx_lg[0]), .CH2_GUARD_LOST_IN(rx_lg[1]),
      .CH1_PERMISSIVE_RECEIVE(obs[0]), .CH2_PERMISSIVE_RECEIVE(obs[1]),
      .CH1_UNBLOCK_BLOCK(obs[2]), .CH2_UNBLOCK_BLOCK(obs[3]),
      .COMBINED_UNBLOCK_BLOCK(obs[4]), .COMBINED_PERMISSIVE_RECEIVE(obs[5]),
      .ECHO_PERMISSIVE_IN(obs[6]), .POTT_ENABLE(obs[7]), .IRQ(obs[8])
   );

   dcub_rx_model rx
   (
      .clk(REF_CLK), .rst_n(RST_N), .slow(slow), .cmd_pt(cmd_pt), .cmd_lg(cmd_lg),
      .pt(rx_pt), .lg(rx_lg)
   );

   task automatic print_verdict();
      $display("tests=%0d failures=%0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         n_fail++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic check_bit(input logic got, input logic exp);
      check_word({31'h0, got}, {31'h0, exp});
   endtask

   task automatic check_range(input int got, input int lo, input int hi);
      n_tests++;
      if (got < lo || got > hi)
      begin
         n_fail++;
         $display("[FAIL] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
      end
   endtask

   // one apb transfer; ready, read data and error taken at one rising edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge REF_CLK);
      PSEL   <= 1'h1;
      PWRITE <= wr;
      PADDR  <= a;
      PWDATA <= wd;
      @(posedge REF_CLK);
      PENABLE <= 1'h1;
      @(posedge REF_CLK);
      while (PREADY !== 1'h1 && n < 20)
      begin
         @(posedge REF_CLK);
         n++;
      end
      rd  = PRDATA;
      err = PSLVERR;
      PSEL    <= 1'h0;
      PENABLE <= 1'h0;
      check_bit(n < 20, 1'h1);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'h1, a, d);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'h0, a, 32'h0);
      check_word(rd, exp);
   endtask

   // cycles until output bit idx shows v, judged against a window; returns after a rising edge
   task automatic wait_obs(input int idx, input logic v, input int lo, input int hi);
      int n;
      n = 0;
      @(negedge REF_CLK);
      while (obs[idx] !== v && n < hi + 8)
      begin
         @(negedge REF_CLK);
         n++;
      end
      @(posedge REF_CLK);
      check_range(n, lo, hi);
   endtask

   task automatic t_reset();
      rd_chk(`DCUB_ADDR_CTRL, 32'h0);
      rd_chk(`DCUB_ADDR_QUAL_DLY, 32'h2);
      rd_chk(`DCUB_ADDR_DIS_DLY, 32'h24);
      rd_chk(`DCUB_ADDR_GUARD_DLY, 32'h28);
      rd_chk(`DCUB_ADDR_INT_MASK, 32'h0);
      check_word({23'h0, obs}, 32'h0);
      apb(1'h0, 8'h1C, 32'h0);
      check_bit(err, 1'h1);
      wr(`DCUB_ADDR_QUAL_DLY, 32'h1);
      wr(`DCUB_ADDR_DIS_DLY, 32'h3);
      wr(`DCUB_ADDR_GUARD_DLY, 32'h4);
      wr(`DCUB_ADDR_INT_MASK, 32'hF);
   endtask

   task automatic t_idle();
      int s;
      for (s = 0; s < 4; s++)
      begin
         wr(`DCUB_ADDR_CTRL, 32'(s));
         repeat (3) @(posedge REF_CLK);
         check_bit(obs[7], s != 0);
      end
      for (s = 0; s < 2; s++)
      begin
         wr(`DCUB_ADDR_CTRL, 32'(s));
         cmd_lg <= 2'h3;
         repeat (40) @(posedge REF_CLK);
         check_word({23'h0, obs}, s ? 32'h80 : 32'h0);
      end
      cmd_pt <= 2'h1;
      wait_obs(ECH, 1'h1, 2, 6);
      cmd_pt <= 2'h0;
      cmd_lg <= 2'h0;
      repeat (10) @(posedge REF_CLK);
   endtask

   task automatic t_two();
      wr(`DCUB_ADDR_CTRL, 32'(DCUB_SCH_UB2T));
      cmd_pt <= 2'h2;
      cmd_lg <= 2'h2;
      repeat (40) @(posedge REF_CLK);
      check_word({23'h0, obs}, 32'h80);
      cmd_pt <= 2'h1;
      wait_obs(PR1, 1'h1, 2, 6);
      @(posedge REF_CLK);
      check_word({23'h0, obs}, 32'hE1);
      cmd_pt <= 2'h0;
      cmd_lg <= 2'h1;
      wait_obs(PR1, 1'h0, 4, 6);
      wait_obs(PR1, 1'h1, 3, 6);
      wait_obs(UB1, 1'h1, 13, 19);
      @(posedge REF_CLK);
      check_bit(obs[CUB], 1'h1);
      check_bit(obs[IRQ_B], 1'h1);
      rd_chk(`DCUB_ADDR_STATE, 32'hB5);
      rd_chk(`DCUB_ADDR_INT_STAT, 32'h5);
      wr(`DCUB_ADDR_INT_MASK, 32'h0);
      @(posedge REF_CLK);
      check_bit(obs[IRQ_B], 1'h0);
      wr(`DCUB_ADDR_INT_STAT, 32'h5);
      wr(`DCUB_ADDR_INT_MASK, 32'hF);
      rd_chk(`DCUB_ADDR_INT_STAT, 32'h0);
      check_bit(obs[IRQ_B], 1'h0);
      cmd_lg <= 2'h0;
      repeat (10) @(posedge REF_CLK);
      cmd_lg <= 2'h1;
      repeat (2) @(posedge REF_CLK);
      cmd_lg <= 2'h0;
      wait_obs(UB1, 1'h0, 19, 28);
      check_bit(obs[PR1] | obs[CUB], 1'h0);
   endtask

   task automatic t_perm_guard();
      slow <= 1'h1;
      cmd_pt <= 2'h1;
      cmd_lg <= 2'h1;
      repeat (60) @(posedge REF_CLK);
      rd_chk(`DCUB_ADDR_STATE, 32'h51);
      cmd_pt <= 2'h0;
      cmd_lg <= 2'h0;
      slow <= 1'h0;
      repeat (10) @(posedge REF_CLK);
   endtask

   task automatic t_three();
      wr(`DCUB_ADDR_CTRL, 32'(DCUB_SCH_UB3T));
      cmd_pt <= 2'h1;
      wait_obs(PR1, 1'h1, 2, 6);
      repeat (3) @(posedge REF_CLK);
      check_bit(obs[CPR] | obs[ECH], 1'h0);
      cmd_lg <= 2'h2;
      wait_obs(PR2, 1'h1, 6, 14);
      @(posedge REF_CLK);
      check_bit(obs[CPR], 1'h1);
      wait_obs(UB2, 1'h1, 12, 19);
      @(posedge REF_CLK);
      check_word({30'h0, obs[CUB], obs[UB1]}, 32'h2);
      check_bit(obs[ECH], 1'h0);
      cmd_pt <= 2'h3;
      wait_obs(ECH, 1'h1, 2, 6);
      cmd_lg <= 2'h0;
      wait_obs(UB2, 1'h0, 19, 28);
   endtask

   initial
   begin
      REF_CLK = 1'h0;
      forever #25 REF_CLK = ~REF_CLK;
   end

   always @(posedge REF_CLK)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         n_fail++;
         print_verdict();
      end
   end

   initial
   begin
      {RST_N, PSEL, PENABLE, PWRITE, slow, cmd_pt, cmd_lg} = 0;
      PADDR = 8'h00;
      PWDATA = 32'h0;
      n_fail = 0;
      n_tests = 0;
      cyc = 0;
      repeat (16) @(posedge REF_CLK);
      RST_N <= 1'h1;
      t_reset();
      t_idle();
      t_two();
      t_perm_guard();
      t_three();
      print_verdict();
   end
endmodule

`default_nettype wire
